// ===== flash_pkg.sv
package flash_pkg;
  // Clock and timing
  localparam int CLK_NS = 40;
  localparam int DP_NS  = 3000;
  localparam int RDP_NS = 30000;
  localparam int RCV_NS = 2000;
  localparam logic [15:0] DP_CYC  = 16'((DP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] RDP_CYC = 16'((RDP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] RCV_CYC = 16'((RCV_NS + CLK_NS - 1) / CLK_NS);
  // Opcodes
  localparam logic [7:0] OP_EN4B   = 8'hB7;
  localparam logic [7:0] OP_EX4B   = 8'hE9;
  localparam logic [7:0] OP_DPD    = 8'hB9;
  localparam logic [7:0] OP_RDPD   = 8'hAB;
  localparam logic [7:0] OP_QEN    = 8'h35;
  localparam logic [7:0] OP_QEX    = 8'hF5;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_RDBK   = 8'h96;
  localparam logic [7:0] OP_CRC    = 8'h9B;
  localparam logic [7:0] OP_CRCSUB = 8'h27;
  localparam logic [7:0] OP_CRCRNG = 8'hFE;
  // Frame sizes in bits; readback length in bytes
  localparam logic [7:0] ONE_BYTE = 8'h08;
  localparam logic [7:0] CRC_BITS = 8'h98;
  localparam logic [7:0] RDBK_LEN = 8'h08;
  // Flag status bit positions
  localparam int FS_ABORT = 1;
  localparam int FS_SUSP  = 2;
  localparam int FS_FAIL  = 4;
  // ECMA generator, x^64 term implied
  localparam logic [63:0] CRC_POLY = 64'h42F0E1EBA9EA3693;
  // Host link timing
  localparam logic [3:0]  HALF_CYC = 4'h8;
  localparam logic [15:0] GAP_CYC  = 16'h0010;
  // Host register byte offsets
  localparam logic [7:0] A_TX0  = 8'h00;
  localparam logic [7:0] A_CMD  = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_RX0  = 8'h1C;
  localparam logic [7:0] A_RX1  = 8'h20;
  localparam logic [7:0] A_PIN  = 8'h24;
endpackage

// ===== flash_link_if.sv
`timescale 1ns/10ps
interface flash_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic rst_n;
  modport host (output cs_n, output sclk, output mosi, output rst_n, input miso);
  modport dev  (input cs_n, input sclk, input mosi, input rst_n, output miso);
endinterface

// ===== crc64_byte.sv
`timescale 1ns/10ps
module crc64_byte (
  input  wire logic [63:0] crc_in,
  input  wire logic [7:0]  data,
  output logic      [63:0] crc_out
);
  logic fb;
  always_comb begin
    fb = 1'b0;
    crc_out = crc_in;
    for (int i = 0; i < 8; i++) begin
      fb = crc_out[63] ^ data[i];
      crc_out = {crc_out[62:0], 1'b0} ^ (fb ? flash_pkg::CRC_POLY : 64'h0);
    end
  end
endmodule

// ===== flash_dev.sv
`timescale 1ns/10ps
// Behaviour
// - Three-byte default, four-byte switch immediate
// - Power-down after entry delay following opcode
// - Power-down refused during write operation
// - In power-down ignore all but release/reset
// - Release void with extra clocks
// - Standby after release delay, chip select high
// - Reset leaves power-down via recovery time
// - Quad protocol enter/leave immediate, no WRITE_ENABLE_LATCH
// - CRC-64 ECMA over range, compare expected
// - LSB first, zero initial value
// - CRC runs regardless of write enable latch
// - Stop below start aborts, flag bit 1
// - Byte-granular range within one die
// - Mismatch sets flag bit 4
// - Suspend sets bit 2, resume clears
// - Resets abort running CRC
// - Failed CRC stored, read LSB first
// - Readback cleared at every CRC start
// - Readback volatile, zeros past end
// - Host sends fixed CRC byte order
// - CRC starts at chip select rise
// - Flag bit 4 shared with program failure
module flash_dev (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  flash_link_if.dev        link,
  input  wire logic        write_busy,
  input  wire logic        suspend_req,
  input  wire logic        sw_reset,
  input  wire logic        flag_clear,
  input  wire logic [7:0]  mem_rdata,
  output logic      [31:0] mem_addr,
  output logic             crc_busy,
  output logic      [7:0]  flag_status,
  output logic             four_byte_mode,
  output logic             quad_mode,
  output logic             deep_power_down,
  output logic             standby
);
  typedef enum logic [2:0] {ST_STBY, ST_ENTER, ST_DOWN, ST_REL, ST_RCV} pwr_type;
  typedef struct packed {
    logic [2:0]   cs_s;
    logic [2:0]   sclk_s;
    logic [1:0]   mosi_s;
    logic [1:0]   rst_s;
    pwr_type      pwr;
    logic [15:0]  dly;
    logic [7:0]   nbits;
    logic [7:0]   sr;
    logic [7:0]   op;
    logic [143:0] arg;
    logic [7:0]   osr;
    logic [7:0]   ridx;
    logic         miso;
    logic         four_b;
    logic         quad;
    logic [7:0]   fsr;
    logic         busy;
    logic [31:0]  cur;
    logic [31:0]  last;
    logic [63:0]  crc;
    logic [63:0]  expect_crc;
    logic [63:0]  rdbk;
  } st_type;

  st_type      q;
  st_type      d;
  logic [63:0] crc_nx;
  logic        rise;
  logic        fall;
  logic        cs_rise;
  logic        cs_fall;
  logic        cs_low;
  logic        in_down;
  logic        one_op;
  logic        rst_ev;
  logic [7:0]  b;
  logic [7:0]  rd_op;

  crc64_byte u_crc (
    .crc_in  (q.crc),
    .data    (mem_rdata),
    .crc_out (crc_nx)
  );

  always_comb begin
    d = q;
    // Pins cross into hclk through two flops; edges use the second and third
    d.cs_s   = {q.cs_s[1:0], link.cs_n};
    d.sclk_s = {q.sclk_s[1:0], link.sclk};
    d.mosi_s = {q.mosi_s[0], link.mosi};
    d.rst_s  = {q.rst_s[0], link.rst_n};
    rise     = q.sclk_s[1] & ~q.sclk_s[2];
    fall     = ~q.sclk_s[1] & q.sclk_s[2];
    cs_rise  = q.cs_s[1] & ~q.cs_s[2];
    cs_fall  = ~q.cs_s[1] & q.cs_s[2];
    cs_low   = ~q.cs_s[1];
    in_down  = (q.pwr == ST_ENTER) || (q.pwr == ST_DOWN);
    one_op   = cs_rise && (q.nbits == flash_pkg::ONE_BYTE);
    rst_ev   = ~q.rst_s[1] | sw_reset;
    b        = {q.sr[6:0], q.mosi_s[1]};
    rd_op    = (q.nbits == 8'h07) ? b : q.op;

    if (flag_clear) begin
      d.fsr = 8'h00;
    end
    if (cs_fall) begin
      d.nbits = 8'h00;
      d.ridx  = 8'h00;
    end
    if (rise && cs_low) begin
      d.sr = b;
      if (q.nbits != 8'hFF) begin
        d.nbits = q.nbits + 8'h01;
      end
      if (q.nbits[2:0] == 3'h7) begin
        if (q.nbits == 8'h07) begin
          d.op = b;
        end else begin
          d.arg = {b, q.arg[143:8]};
        end
        if ((q.pwr == ST_STBY) && (rd_op == flash_pkg::OP_RDBK)) begin
          d.osr = (q.ridx < flash_pkg::RDBK_LEN) ? q.rdbk[{q.ridx[2:0], 3'h0} +: 8] : 8'h00;
          if (q.ridx != 8'hFF) begin
            d.ridx = q.ridx + 8'h01;
          end
        end
      end
    end
    if (fall && cs_low) begin
      d.miso = q.osr[7];
      d.osr  = {q.osr[6:0], 1'b0};
    end

    // Delayed power transitions
    case (q.pwr)
      ST_STBY, ST_DOWN: begin
      end
      ST_ENTER, ST_REL, ST_RCV: begin
        if (q.dly == 16'h0000) begin
          d.pwr = (q.pwr == ST_ENTER) ? ST_DOWN : ST_STBY;
        end else begin
          d.dly = q.dly - 16'h0001;
        end
      end
      default: d.pwr = ST_STBY;
    endcase

    if (in_down && one_op && (q.op == flash_pkg::OP_RDPD)) begin
      d.pwr = ST_REL;
      d.dly = flash_pkg::RDP_CYC;
    end

    if ((q.pwr == ST_STBY) && one_op) begin
      case (q.op)
        flash_pkg::OP_EN4B: d.four_b = 1'b1;
        flash_pkg::OP_EX4B: d.four_b = 1'b0;
        flash_pkg::OP_QEN: d.quad = 1'b1;
        flash_pkg::OP_QEX: d.quad = 1'b0;
        flash_pkg::OP_RESUME: d.fsr[flash_pkg::FS_SUSP] = 1'b0;
        flash_pkg::OP_DPD: begin
          if (!write_busy && !q.busy) begin
            d.pwr = ST_ENTER;
            d.dly = flash_pkg::DP_CYC;
          end
        end
        default: begin
        end
      endcase
    end

    // Start at cs rise; latch not consulted
    if ((q.pwr == ST_STBY) && cs_rise && !q.busy && (q.nbits == flash_pkg::CRC_BITS) &&
        (q.op == flash_pkg::OP_CRC) && (q.arg[7:0] == flash_pkg::OP_CRCSUB) &&
        (q.arg[15:8] == flash_pkg::OP_CRCRNG)) begin
      d.rdbk = 64'h0;
      if (q.arg[143:112] < q.arg[111:80]) begin
        d.fsr[flash_pkg::FS_ABORT] = 1'b1;
      end else begin
        d.busy       = 1'b1;
        d.cur        = q.arg[111:80];
        d.last       = q.arg[143:112];
        d.crc        = 64'h0;
        d.expect_crc = q.arg[79:16];
      end
    end

    // One byte per cycle; memory answers in the same cycle
    if (q.busy) begin
      d.crc = crc_nx;
      d.cur = q.cur + 32'h0000_0001;
      if (q.cur == q.last) begin
        d.busy = 1'b0;
        if (crc_nx != q.expect_crc) begin
          d.fsr[flash_pkg::FS_FAIL] = 1'b1;
          d.rdbk = crc_nx;
        end
      end
    end
    if (q.busy && suspend_req) begin
      d.fsr[flash_pkg::FS_SUSP] = 1'b1;
    end

    if (rst_ev) begin
      d.busy   = 1'b0;
      d.rdbk   = 64'h0;
      d.four_b = 1'b0;
      d.quad   = 1'b0;
      d.fsr    = 8'h00;
      d.pwr    = ST_RCV;
      d.dly    = flash_pkg::RCV_CYC;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q        <= '0;
      q.cs_s   <= 3'h7;
      q.rst_s  <= 2'h3;
      q.pwr    <= ST_STBY;
    end else begin
      q <= d;
    end
  end

  assign link.miso       = q.miso;
  assign mem_addr        = q.cur;
  assign crc_busy        = q.busy;
  assign flag_status     = q.fsr;
  assign four_byte_mode  = q.four_b;
  assign quad_mode       = q.quad;
  assign deep_power_down = (q.pwr == ST_DOWN);
  assign standby         = (q.pwr == ST_STBY);
endmodule

// ===== flash_host.sv
`timescale 1ns/10ps
module flash_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  flash_link_if.host       link
);
  typedef enum logic [1:0] {H_IDLE, H_LEAD, H_BITS, H_GAP} hst_type;
  typedef struct packed {
    hst_type      st;
    logic         wr_pend;
    logic [7:0]   wa;
    logic [31:0]  rdata;
    logic [159:0] tx;
    logic [4:0]   txn;
    logic [3:0]   rxn;
    logic [7:0]   tot;
    logic         op_rel;
    logic [3:0]   div;
    logic [7:0]   bits;
    logic [63:0]  rx;
    logic [1:0]   miso_s;
    logic         cs_n;
    logic         sclk;
    logic         mosi;
    logic         pin_rst;
    logic [15:0]  gap;
  } hs_type;

  hs_type     q;
  hs_type     d;
  logic       addr_ok;
  logic [7:0] txbits;
  logic [7:0] r;
  logic [7:0] nby;
  logic       txbit;
  logic       lone;

  always_comb begin
    d        = q;
    d.miso_s = {q.miso_s[0], link.miso};
    addr_ok  = hsel && htrans[1] && hready;
    txbits   = {q.txn, 3'h0};
    r        = q.bits - txbits;
    nby      = 8'(hwdata[4:0]) + 8'(hwdata[11:8]);
    txbit    = (q.bits < txbits) ? q.tx[{q.bits[7:3], ~q.bits[2:0]}] : 1'b0;
    lone     = (q.tx[7:0] == flash_pkg::OP_DPD) || (q.tx[7:0] == flash_pkg::OP_RDPD) ||
               (q.tx[7:0] == flash_pkg::OP_QEN) || (q.tx[7:0] == flash_pkg::OP_QEX);

    d.wr_pend = addr_ok && hwrite;
    if (addr_ok) begin
      d.wa = haddr[7:0];
      case (haddr[7:0])
        flash_pkg::A_CMD:  d.rdata = {20'h0, q.rxn, 3'h0, q.txn};
        flash_pkg::A_STAT: d.rdata = {31'h0, q.st != H_IDLE};
        flash_pkg::A_RX0:  d.rdata = q.rx[31:0];
        flash_pkg::A_RX1:  d.rdata = q.rx[63:32];
        flash_pkg::A_PIN:  d.rdata = {31'h0, q.pin_rst};
        default:           d.rdata = 32'h0;
      endcase
    end
    if (q.wr_pend) begin
      if (q.wa == flash_pkg::A_PIN) begin
        d.pin_rst = hwdata[0];
      end
      if (q.st == H_IDLE) begin
        if ((q.wa < flash_pkg::A_CMD) && (q.wa[1:0] == 2'h0)) begin
          d.tx[{q.wa[4:2], 5'h0} +: 32] = hwdata;
        end
        if (q.wa == flash_pkg::A_CMD) begin
          d.txn    = hwdata[4:0];
          d.rxn    = hwdata[11:8];
          d.op_rel = (q.tx[7:0] == flash_pkg::OP_RDPD);
          // Lone opcodes end after eight bits; no extra clocks; no prefix
          d.tot    = lone ? flash_pkg::ONE_BYTE : {nby[4:0], 3'h0};
          d.st     = H_LEAD;
          d.cs_n   = 1'b0;
          d.div    = 4'h0;
          d.bits   = 8'h00;
          d.rx     = 64'h0;
        end
      end
    end

    case (q.st)
      H_IDLE: begin
      end
      H_LEAD: begin
        d.mosi = txbit;
        d.div  = q.div + 4'h1;
        if (q.div == flash_pkg::HALF_CYC - 4'h1) begin
          d.div = 4'h0;
          d.st  = H_BITS;
        end
      end
      H_BITS: begin
        // Bytes in buffer order, MSB first
        if (!q.sclk) begin
          d.mosi = txbit;
        end
        d.div = q.div + 4'h1;
        if (q.div == flash_pkg::HALF_CYC - 4'h1) begin
          d.div  = 4'h0;
          d.sclk = ~q.sclk;
          if (q.sclk) begin
            if ((q.bits >= txbits) && (r[7:6] == 2'h0)) begin
              d.rx[{r[5:3], ~r[2:0]}] = q.miso_s[1];
            end
            d.bits = q.bits + 8'h01;
            if (q.bits + 8'h01 == q.tot) begin
              // Raise cs after last byte; hold it through release
              d.st  = H_GAP;
              d.gap = q.op_rel ? flash_pkg::RDP_CYC : flash_pkg::GAP_CYC;
            end
          end
        end
      end
      H_GAP: begin
        d.cs_n = 1'b1;
        d.mosi = 1'b0;
        d.gap  = q.gap - 16'h0001;
        if (q.gap == 16'h0000) begin
          d.st = H_IDLE;
        end
      end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q      <= '0;
      q.st   <= H_IDLE;
      q.cs_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = q.rdata;
  assign link.cs_n  = q.cs_n;
  assign link.sclk  = q.sclk;
  assign link.mosi  = q.mosi;
  assign link.rst_n = ~q.pin_rst;
endmodule

// ===== flash_mode_power_crc_commands_asserts.sv
`timescale 1ns/10ps
module flash_mode_power_crc_commands_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic rst_n
);
  logic       sclk_q;
  logic [2:0] bits_q;
  // Rising link clock edges in the frame, modulo one byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_q <= 1'b0;
      bits_q <= 3'h0;
    end else begin
      sclk_q <= sclk;
      if (cs_n)
        bits_q <= 3'h0;
      else if (sclk && !sclk_q)
        bits_q <= bits_q + 3'h1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  idle_low_a: assert property (sclk |-> !cs_n)
    else $error("link clock high outside a frame");
  start_delay_a: assert property ($fell(cs_n) |-> !sclk [*8])
    else $error("link clock rose too soon after select");
  high_phase_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("link clock high phase wrong");
  low_phase_a: assert property ($fell(sclk) && !cs_n |-> !sclk [*8])
    else $error("link clock low phase wrong");
  end_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select high time too short");
  last_fall_a: assert property ($rose(cs_n) |-> !sclk && !$past(sclk))
    else $error("select rose with link clock high");
  whole_bytes_a: assert property ($rose(cs_n) |-> bits_q == 3'h0)
    else $error("frame not whole bytes");
  data_hold_a: assert property (!cs_n && sclk && $past(sclk) |-> $stable(mosi))
    else $error("data changed while clock high");
endmodule

// ===== flash_mode_power_crc_commands_tb.sv
`timescale 1ns/10ps
module flash_mode_power_crc_commands_tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  wire logic   hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        write_busy;
  logic        suspend_req;
  logic        sw_reset;
  logic        flag_clear;
  logic [7:0]  mem_rdata;
  logic [31:0] mem_addr;
  logic        crc_busy;
  logic [7:0]  flag_status;
  logic        four_byte_mode;
  logic        quad_mode;
  logic        deep_power_down;
  logic        standby;
  logic [31:0] r;
  logic [63:0] v;
  int          miscompares = 0;
  int          checks = 0;
  int          cyc = 0;
  // Rows: opcode, expected four-byte mode, expected quad mode
  logic [9:0]  rows [4] = '{10'h2DE, 10'h3A4, 10'h0D5, 10'h3D4};
  assign hready = hreadyout;
  // Array contents are a simple function of the address
  assign mem_rdata = mem_addr[7:0] ^ 8'h5A;
  flash_link_if flash_link_if_i ();
  flash_host flash_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(flash_link_if_i));
  flash_dev flash_dev_i (.hclk(hclk), .hresetn(hresetn), .link(flash_link_if_i),
    .write_busy(write_busy), .suspend_req(suspend_req), .sw_reset(sw_reset),
    .flag_clear(flag_clear), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .crc_busy(crc_busy),
    .flag_status(flag_status), .four_byte_mode(four_byte_mode), .quad_mode(quad_mode),
    .deep_power_down(deep_power_down), .standby(standby));
  flash_mode_power_crc_commands_asserts flash_mode_power_crc_commands_asserts_i (
    .hclk(hclk), .hresetn(hresetn), .cs_n(flash_link_if_i.cs_n), .sclk(flash_link_if_i.sclk),
    .mosi(flash_link_if_i.mosi), .miso(flash_link_if_i.miso), .rst_n(flash_link_if_i.rst_n));
  initial begin
    hclk = 1'b0;
    forever #(flash_pkg::CLK_NS / 2) hclk = ~hclk;
  end
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic frame(input logic [31:0] cmd);
    logic [31:0] q;
    wr(flash_pkg::A_CMD, cmd);
    q = 32'h1;
    for (int i = 0; i < 2000 && q[0] !== 1'b0; i++)
      bus(flash_pkg::A_STAT, 1'b0, 32'h0, q);
    @(negedge hclk);
    chk(q[0], 1'b0);
  endtask
  task automatic op(input logic [7:0] c);
    wr(flash_pkg::A_TX0, {24'h0, c});
    frame(32'h1);
  endtask
  task automatic rdbk(output logic [63:0] q);
    logic [31:0] lo;
    logic [31:0] hi;
    wr(flash_pkg::A_TX0, {24'h0, flash_pkg::OP_RDBK});
    frame(32'h801);
    bus(flash_pkg::A_RX0, 1'b0, 32'h0, lo);
    bus(flash_pkg::A_RX1, 1'b0, 32'h0, hi);
    q = {hi, lo};
  endtask
  // fixed byte order of the check frame; byte-granular bounds
  task automatic crc(input logic [63:0] e, input logic [31:0] s, input logic [31:0] t);
    logic [7:0] m [20];
    m[0] = flash_pkg::OP_CRC;
    m[1] = flash_pkg::OP_CRCSUB;
    m[2] = flash_pkg::OP_CRCRNG;
    m[19] = 8'h00;
    for (int i = 0; i < 8; i++)
      m[3 + i] = e[8 * i +: 8];
    for (int i = 0; i < 4; i++) begin
      m[11 + i] = s[8 * i +: 8];
      m[15 + i] = t[8 * i +: 8];
    end
    for (int i = 0; i < 5; i++)
      wr(8'(4 * i), {m[4 * i + 3], m[4 * i + 2], m[4 * i + 1], m[4 * i]});
    frame(32'h13);
  endtask
  // reference: bytes enter low bit first, register starts at zero
  function automatic logic [63:0] crc_of(input int s, input int t);
    logic [63:0] c;
    logic [7:0]  b;
    logic        f;
    c = 64'h0;
    for (int a = s; a <= t; a++) begin
      b = 8'(a) ^ 8'h5A;
      for (int i = 0; i < 8; i++) begin
        f = c[63] ^ b[i];
        c = {c[62:0], 1'b0} ^ (f ? flash_pkg::CRC_POLY : 64'h0);
      end
    end
    return c;
  endfunction
  task automatic idle_wait;
    for (int i = 0; i < 2000 && crc_busy !== 1'b0; i++)
      @(posedge hclk);
    repeat (3) @(negedge hclk);
    chk(crc_busy, 1'b0);
  endtask
  task automatic pulse(input logic [2:0] p);
    @(posedge hclk);
    {flag_clear, sw_reset, suspend_req} <= p;
    @(posedge hclk);
    {flag_clear, sw_reset, suspend_req} <= 3'h0;
    repeat (3) @(negedge hclk);
  endtask
  initial begin
    {hsel, hwrite, write_busy, flag_clear, sw_reset, suspend_req, hresetn} <= 7'h00;
    {haddr, hwdata} <= 64'h0;
    htrans <= 2'h0;
    hsize <= 3'h2;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk({four_byte_mode, quad_mode, deep_power_down, standby, flag_status}, 64'h100);
    bus(8'h40, 1'b0, 32'h0, r);
    chk({hreadyout, hresp, r}, 34'h200000000);
    for (int i = 0; i < 4; i++) begin
      op(rows[i][9:2]);
      chk({four_byte_mode, quad_mode}, rows[i][1:0]);
    end
    @(posedge hclk);
    write_busy <= 1'b1;
    op(flash_pkg::OP_DPD);
    repeat (flash_pkg::DP_CYC + 10) @(negedge hclk);
    chk(deep_power_down, 1'b0);
    @(posedge hclk);
    write_busy <= 1'b0;
    op(flash_pkg::OP_DPD);
    chk(deep_power_down, 1'b0);
    repeat (flash_pkg::DP_CYC) @(negedge hclk);
    chk({deep_power_down, standby}, 2'h2);
    op(flash_pkg::OP_QEN);
    chk(quad_mode, 1'b0);
    op(flash_pkg::OP_RDPD);
    repeat (flash_pkg::RDP_CYC + 10) @(negedge hclk);
    chk({deep_power_down, standby}, 2'h1);
    // pin reset leaves power-down after recovery
    op(flash_pkg::OP_DPD);
    repeat (flash_pkg::DP_CYC + 10) @(negedge hclk);
    wr(flash_pkg::A_PIN, 32'h1);
    bus(flash_pkg::A_PIN, 1'b0, 32'h0, r);
    chk(r, 32'h1);
    wr(flash_pkg::A_PIN, 32'h0);
    @(negedge hclk);
    chk(standby, 1'b0);
    repeat (flash_pkg::RCV_CYC + 20) @(negedge hclk);
    chk({deep_power_down, standby}, 2'h1);
    // suspend flagged but check completes, zero readback on pass
    crc(crc_of(0, 255), 32'h0, 32'hFF);
    chk(crc_busy, 1'b1);
    pulse(3'h1);
    chk({crc_busy, flag_status[2]}, 2'h3);
    idle_wait();
    chk(flag_status, 8'h04);
    op(flash_pkg::OP_RESUME);
    chk(flag_status, 8'h00);
    rdbk(v);
    chk(v, 64'h0);
    // Mismatch stores the computed value
    crc(crc_of(16, 19) ^ 64'h1, 32'h10, 32'h13);
    idle_wait();
    chk(flag_status[4], 1'b1);
    rdbk(v);
    chk(v, crc_of(16, 19));
    bus(flash_pkg::A_CMD, 1'b0, 32'h0, r);
    chk(r, 32'h801);
    // A passing check after a failing one must read back zeros
    crc(crc_of(16, 19), 32'h10, 32'h13);
    idle_wait();
    rdbk(v);
    chk(v, 64'h0);
    pulse(3'h2);
    repeat (flash_pkg::RCV_CYC + 20) @(negedge hclk);
    chk({flag_status, standby}, 9'h001);
    rdbk(v);
    chk(v, 64'h0);
    crc(64'h0, 32'h20, 32'h1F);
    idle_wait();
    chk(flag_status, 8'h02);
    pulse(3'h4);
    chk(flag_status, 8'h00);
    // software reset aborts a running check
    crc(64'h0, 32'h0, 32'hFF);
    pulse(3'h2);
    chk(crc_busy, 1'b0);
    repeat (300) @(negedge hclk);
    chk(flag_status, 8'h00);
    give_verdict();
  end
endmodule
